// File: logic/psc_strap_loader.sv
// Power-up strap capture and decode into configuration settings
`timescale 1ns/10ps
module psc_strap_loader (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [30:0] config_strap_bus,
    input wire logic processor_bus_request,
    input wire logic internal_request,
    output psc_pkg::psc_cfg_t cfg,
    output logic cfg_valid,
    output logic processor_bus_grant,
    output logic internal_grant
);
    typedef enum logic [1:0] {
        PSC_S_SAMPLE = 2'b01,
        PSC_S_HOLD = 2'b10
    } psc_load_state_t;

    psc_load_state_t state_q;
    psc_load_state_t state_d;
    logic [30:0] strap_q;
    logic [30:0] strap_d;
    psc_pkg::psc_cfg_t cfg_q;
    psc_pkg::psc_cfg_t cfg_d;

    function automatic logic [31:0] base_decode(input logic [1:0] code);
        if (code == 2'b00) begin
            base_decode = psc_pkg::CSR_BASE_00;
        end else if (code == 2'b01) begin
            base_decode = psc_pkg::CSR_BASE_01;
        end else if (code == 2'b10) begin
            base_decode = psc_pkg::CSR_BASE_10;
        end else begin
            base_decode = psc_pkg::CSR_BASE_11;
        end
    endfunction : base_decode

    // Straps are caught on the first edge after reset release, never during the async reset
    always_comb begin
        state_d = state_q;
        strap_d = strap_q;
        case (state_q)
            PSC_S_SAMPLE: begin
                strap_d = config_strap_bus;
                state_d = PSC_S_HOLD;
            end
            PSC_S_HOLD: begin
                strap_d = strap_q;
            end
            default: begin
                state_d = PSC_S_SAMPLE;
            end
        endcase
    end

    always_comb begin
        logic [30:0] s;
        logic p0;
        s = strap_q;
        p0 = s[psc_pkg::POS_P0_RV];
        cfg_d = '0;
        cfg_d.powerup_header_bit = s[psc_pkg::POS_HDR_LO +: 4];
        cfg_d.pci_class_code_field = s[psc_pkg::POS_CLASS] ?
            psc_pkg::CLASS_I2O : psc_pkg::CLASS_BRIDGE;
        cfg_d.pci_arb_en = s[psc_pkg::POS_PCI_ARB];
        cfg_d.cpu_arb_en = s[psc_pkg::POS_CPU_ARB];
        cfg_d.bridge_csr_group = base_decode(s[psc_pkg::POS_BASE_LO +: 2]);
        cfg_d.ratio = psc_pkg::psc_ratio_t'(s[psc_pkg::POS_RATIO_LO +: 3]);
        case (cfg_d.ratio)
            psc_pkg::PSC_R_RSVD0, psc_pkg::PSC_R_RSVD5, psc_pkg::PSC_R_RSVD7: begin
                cfg_d.ratio_reserved = 1'b1;
            end
            default: begin
                cfg_d.ratio_reserved = 1'b0;
            end
        endcase
        cfg_d.port0_data_width = s[psc_pkg::POS_P0_DW_LO +: 2];
        cfg_d.port1_data_width = s[psc_pkg::POS_P1_DW_LO +: 2];
        cfg_d.port2_data_width = s[psc_pkg::POS_P2_DW_LO +: 2];
        cfg_d.port3_data_width = s[psc_pkg::POS_P3_DW_LO +: 2];
        cfg_d.port_rv_en = {s[psc_pkg::POS_P3_RV], s[psc_pkg::POS_P2_RV],
            s[psc_pkg::POS_P1_RV], p0};
        // Fixed priority: lowest enabled port sources the reset vector
        if (p0) begin
            cfg_d.reset_vector_sel = 4'h1;
        end else if (s[psc_pkg::POS_P1_RV]) begin
            cfg_d.reset_vector_sel = 4'h2;
        end else if (s[psc_pkg::POS_P2_RV]) begin
            cfg_d.reset_vector_sel = 4'h4;
        end else if (s[psc_pkg::POS_P3_RV]) begin
            cfg_d.reset_vector_sel = 4'h8;
        end else begin
            cfg_d.reset_vector_sel = 4'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSC_S_SAMPLE;
            strap_q <= psc_pkg::STRAP_RESET;
            cfg_q <= '0;
        end else begin
            state_q <= state_d;
            strap_q <= strap_d;
            cfg_q <= cfg_d;
        end
    end

    // Settings are valid one cycle after capture, once the decode has registered
    logic valid_q;
    logic valid_d;
    always_comb begin
        valid_d = (state_q == PSC_S_HOLD);
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
        end
    end

    assign cfg = cfg_q;
    assign cfg_valid = valid_q;

    psc_arbiter u_arbiter (
        .clock(clock),
        .rst_n(rst_n),
        .enable(cfg_q.cpu_arb_en && valid_q),
        .processor_bus_request(processor_bus_request),
        .internal_request(internal_request),
        .processor_bus_grant(processor_bus_grant),
        .internal_grant(internal_grant)
    );
endmodule : psc_strap_loader

// File: common/psc_pkg.sv
// Package of constants and types for the power-up strap configuration loader
package psc_pkg;
    localparam int STRAP_W = 31;
    localparam int POS_HDR_LO = 20;
    localparam int POS_CLASS = 19;
    localparam int POS_PCI_ARB = 18;
    localparam int POS_CPU_ARB = 17;
    localparam int POS_BASE_LO = 15;
    localparam int POS_RATIO_LO = 12;
    localparam int POS_P0_DW_LO = 10;
    localparam int POS_P0_RV = 9;
    localparam int POS_P1_DW_LO = 7;
    localparam int POS_P1_RV = 6;
    localparam int POS_P2_DW_LO = 4;
    localparam int POS_P2_RV = 3;
    localparam int POS_P3_DW_LO = 1;
    localparam int POS_P3_RV = 0;
    localparam logic [30:0] STRAP_RESET = 31'h00000000;
    localparam logic [31:0] CSR_BASE_00 = 32'hfeff0000;
    localparam logic [31:0] CSR_BASE_01 = 32'hfefe0000;
    localparam logic [31:0] CSR_BASE_10 = 32'hfefd0000;
    localparam logic [31:0] CSR_BASE_11 = 32'hfefc0000;
    localparam logic [23:0] CLASS_BRIDGE = 24'h068000;
    localparam logic [23:0] CLASS_I2O = 24'h0e0000;

    typedef enum logic [2:0] {
        PSC_R_RSVD0 = 3'h0,
        PSC_R_3_2 = 3'h1,
        PSC_R_2_1 = 3'h2,
        PSC_R_5_2 = 3'h3,
        PSC_R_1_1 = 3'h4,
        PSC_R_RSVD5 = 3'h5,
        PSC_R_3_1 = 3'h6,
        PSC_R_RSVD7 = 3'h7
    } psc_ratio_t;

    typedef struct packed {
        logic [3:0] powerup_header_bit;
        logic [23:0] pci_class_code_field;
        logic pci_arb_en;
        logic cpu_arb_en;
        logic [31:0] bridge_csr_group;
        psc_ratio_t ratio;
        logic ratio_reserved;
        logic [1:0] port0_data_width;
        logic [1:0] port1_data_width;
        logic [1:0] port2_data_width;
        logic [1:0] port3_data_width;
        logic [3:0] port_rv_en;
        logic [3:0] reset_vector_sel;
    } psc_cfg_t;
endpackage : psc_pkg

// File: logic/psc_arbiter.sv
// Processor-bus arbiter between the processor and the internal bus master
`timescale 1ns/10ps
module psc_arbiter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic processor_bus_request,
    input wire logic internal_request,
    output logic processor_bus_grant,
    output logic internal_grant
);
    typedef enum logic [2:0] {
        PSC_A_IDLE = 3'b001,
        PSC_A_CPU = 3'b010,
        PSC_A_INT = 3'b100
    } psc_arb_state_t;

    psc_arb_state_t state_q;
    psc_arb_state_t state_d;
    logic last_cpu_q;
    logic last_cpu_d;

    // Round robin picks between simultaneous requests in idle; a granted master keeps the bus until its request or enable drops
    always_comb begin
        state_d = state_q;
        last_cpu_d = last_cpu_q;
        case (state_q)
            PSC_A_IDLE: begin
                if (enable) begin
                    if (processor_bus_request && (!internal_request || !last_cpu_q)) begin
                        state_d = PSC_A_CPU;
                        last_cpu_d = 1'b1;
                    end else if (internal_request) begin
                        state_d = PSC_A_INT;
                        last_cpu_d = 1'b0;
                    end
                end
            end
            PSC_A_CPU: begin
                if (!processor_bus_request || !enable) begin
                    state_d = PSC_A_IDLE;
                end
            end
            PSC_A_INT: begin
                if (!internal_request || !enable) begin
                    state_d = PSC_A_IDLE;
                end
            end
            default: begin
                state_d = PSC_A_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSC_A_IDLE;
            last_cpu_q <= 1'b0;
        end else begin
            state_q <= state_d;
            last_cpu_q <= last_cpu_d;
        end
    end

    assign processor_bus_grant = (state_q == PSC_A_CPU);
    assign internal_grant = (state_q == PSC_A_INT);
endmodule : psc_arbiter

// File: testbench/psc_loader_monitor.sv
// Port checker for the strap loader
`timescale 1ns/10ps
module psc_loader_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [30:0] config_strap_bus,
    input wire logic processor_bus_request,
    input wire logic internal_request,
    input wire psc_pkg::psc_cfg_t cfg,
    input wire logic cfg_valid,
    input wire logic processor_bus_grant,
    input wire logic internal_grant
);
    logic seen_q;
    logic [30:0] cap_q;
    // Own copy of the straps at the first edge, so later strap moves cannot mask a fault
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
            cap_q <= 31'h0;
        end else if (!seen_q) begin
            seen_q <= 1'b1;
            cap_q <= config_strap_bus;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence proc_done_s;
        processor_bus_grant ##1 !processor_bus_request;
    endsequence
    hold_cfg_a: assert property (cfg_valid |=> cfg_valid && $stable(cfg))
        else $error("cfg moved");
    header_map_a: assert property (cfg_valid |-> cfg.powerup_header_bit == cap_q[23:20])
        else $error("header bits");
    class_map_a: assert property (cfg_valid |-> cfg.pci_class_code_field ==
        (cap_q[19] ? psc_pkg::CLASS_I2O : psc_pkg::CLASS_BRIDGE)) else $error("class");
    arb_enable_a: assert property (cfg_valid |->
        cfg.pci_arb_en == cap_q[18] && cfg.cpu_arb_en == cap_q[17]) else $error("arb en");
    csr_base_a: assert property (cfg_valid && cap_q[16:15] == 2'h0 |->
        cfg.bridge_csr_group == psc_pkg::CSR_BASE_00) else $error("base");
    ratio_map_a: assert property (cfg_valid |-> cfg.ratio == cap_q[14:12] &&
        cfg.ratio_reserved == (cap_q[14:12] inside {3'h0, 3'h5, 3'h7})) else $error("ratio");
    vector_pick_a: assert property (cfg_valid |-> cfg.reset_vector_sel ==
        (cap_q[9] ? 4'h1 : cap_q[6] ? 4'h2 : cap_q[3] ? 4'h4 : cap_q[0] ? 4'h8 : 4'h0))
        else $error("vector");
    port_width_a: assert property (cfg_valid |->
        cfg.port0_data_width == cap_q[11:10] && cfg.port1_data_width == cap_q[8:7])
        else $error("port width");
    vector_enable_a: assert property (cfg_valid |->
        cfg.port_rv_en == {cap_q[0], cap_q[3], cap_q[6], cap_q[9]}) else $error("vector en");
    grant_one_a: assert property (!(processor_bus_grant && internal_grant))
        else $error("two grants");
    grant_drop_a: assert property (proc_done_s |=> !processor_bus_grant)
        else $error("grant held");
endmodule : psc_loader_chk

bind psc_strap_loader psc_loader_chk u_chk (.clock(clock), .rst_n(rst_n),
    .config_strap_bus(config_strap_bus), .processor_bus_request(processor_bus_request),
    .internal_request(internal_request), .cfg(cfg), .cfg_valid(cfg_valid),
    .processor_bus_grant(processor_bus_grant), .internal_grant(internal_grant));

// File: testbench/psc_board_model.sv
// Board straps: jumpers, fixed pulls and ratio logic
`timescale 1ns/10ps
module psc_board_model (
    input wire logic [3:0] hdr_jumpers,
    input wire logic class_jumper,
    input wire logic pci_66mhz_enable,
    input wire logic alternate_bank_select,
    output logic [30:0] config_strap_bus
);
    logic [2:0] ratio;
    assign ratio = pci_66mhz_enable ? 3'h1 : 3'h6;
    // Bit 18 pulled low: arbitration stays on the baseboard; unused widths float oddly
    assign config_strap_bus = {7'h41, hdr_jumpers, class_jumper, 1'b0, 1'b1, 2'h0,
        ratio, 2'h1, ~alternate_bank_select, 2'h3, 1'b1, 2'h2, 1'b0, 2'h1, 1'b0};
endmodule : psc_board_model

// File: testbench/tb_power_up_strap_config.sv
// Testbench for the strap loader and processor-bus arbiter
`timescale 1ns/10ps
module tb_power_up_strap_config;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] hdr = 4'ha;
    logic cls = 1'b0, m66 = 1'b1, bsel = 1'b0, raw_en = 1'b0, preq = 1'b0, ireq = 1'b0;
    logic [30:0] raw = 31'h0, board, straps;
    psc_pkg::psc_cfg_t cfg;
    logic cfg_valid, pgnt, ignt;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #4 clock = ~clock;
    assign straps = raw_en ? raw : board;
    psc_board_model BRD (.hdr_jumpers(hdr), .class_jumper(cls), .pci_66mhz_enable(m66),
        .alternate_bank_select(bsel), .config_strap_bus(board));
    psc_strap_loader DUT (.clock(clock), .rst_n(rst_n), .config_strap_bus(straps),
        .processor_bus_request(preq), .internal_request(ireq), .cfg(cfg),
        .cfg_valid(cfg_valid), .processor_bus_grant(pgnt), .internal_grant(ignt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic power_up;
        int n;
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        n = 0;
        while (cfg_valid !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        chk(n, 2);
    endtask : power_up
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        power_up();
        chk(cfg.powerup_header_bit, 4'ha);
        chk(cfg.pci_class_code_field, psc_pkg::CLASS_BRIDGE);
        chk(cfg.pci_arb_en, 1'b0);
        chk(cfg.cpu_arb_en, 1'b1);
        chk(cfg.bridge_csr_group, psc_pkg::CSR_BASE_00);
        chk(cfg.ratio, psc_pkg::PSC_R_3_2);
        chk(cfg.port0_data_width, 2'h1);
        chk(cfg.reset_vector_sel, 4'h1);
        chk(cfg.port1_data_width, 2'h3);
        chk(cfg.port_rv_en[3:2], 2'h0);
        hdr = 4'h5;
        cls = 1'b1;
        m66 = 1'b0;
        bsel = 1'b1;
        repeat (4) @(negedge clock);
        chk(cfg.powerup_header_bit, 4'ha);
        chk(cfg.pci_class_code_field, psc_pkg::CLASS_BRIDGE);
        chk(cfg.ratio, psc_pkg::PSC_R_3_2);
        chk(cfg.reset_vector_sel, 4'h1);
        $display("test defaults done");
        power_up();
        chk(cfg.pci_class_code_field, psc_pkg::CLASS_I2O);
        chk(cfg.ratio, psc_pkg::PSC_R_3_1);
        chk(cfg.reset_vector_sel, 4'h2);
        $display("test bank b done");
        raw_en = 1'b1;
        preq = 1'b1;
        for (int c = 0; c < 8; c++) begin
            raw = {16'h0, c[2:0], 12'h0};
            power_up();
            chk(cfg.ratio, c[2:0]);
            chk(cfg.ratio_reserved, c == 0 || c == 5 || c == 7);
            chk(pgnt, 1'b0);
            chk(cfg.reset_vector_sel, 4'h0);
        end
        $display("test ratio done");
        raw_en = 1'b0;
        preq = 1'b0;
        power_up();
        preq = 1'b1;
        repeat (2) @(negedge clock);
        chk({pgnt, ignt}, 2'h2);
        ireq = 1'b1;
        @(negedge clock);
        chk({pgnt, ignt}, 2'h2);
        preq = 1'b0;
        repeat (4) @(negedge clock);
        chk({pgnt, ignt}, 2'h1);
        ireq = 1'b0;
        @(negedge clock);
        $display("test arbiter done");
        results();
    end
endmodule : tb_power_up_strap_config
